/* File: dv/nco_phase_sync_control_and_presets_tb.sv */
// Bench: APB orders to the controller, which drives the device over
// the shared interface; timing pins are driven here directly.
`timescale 1ns/1ps
module nco_phase_sync_control_and_presets_tb;
  localparam logic [11:0] SYNC = ncs_pkg::NCS_OFS_SYNC_CTRL;
  localparam logic [11:0] FRQ  = ncs_pkg::NCS_OFS_FREQ_A0;
  localparam logic [11:0] PHS  = ncs_pkg::NCS_OFS_PHASE_A0;
  logic        mclk, resetn, psel, penable, pwrite, pready, pslverr;
  logic        align_pulse;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, nco_phase;
  logic [1:0]  active_preset;
  int          miscompares, cmp_count, cyc, aligns;

  ncs_if ifc ();
  ncs_ctl u_ncs_ctl (.mclk(mclk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(ifc));
  ncs_device u_ncs_device (.mclk(mclk), .resetn(resetn), .bus(ifc),
    .nco_phase(nco_phase), .active_preset(active_preset),
    .align_pulse(align_pulse));
  ncs_chk u_ncs_chk (.mclk(mclk), .resetn(resetn), .reg_wr(ifc.reg_wr),
    .reg_rd(ifc.reg_rd), .reg_addr(ifc.reg_addr),
    .reg_wdata(ifc.reg_wdata), .reg_ack(ifc.reg_ack),
    .sysref(ifc.sysref), .sync_n(ifc.sync_n), .boundary(ifc.boundary),
    .nco_phase(nco_phase), .active_preset(active_preset),
    .align_pulse(align_pulse));

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Cycle count, alignment count and hang guard
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    aligns <= aligns + int'(align_pulse === 1'b1);
    if (cyc == 8000)
    begin
      miscompares++;
      stop_test();
    end
  end

  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic stop_test();
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Device access through the controller; busy polled before return
  task automatic dev(input logic [2:0] cmd, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    apb(1'b1, ncs_pkg::NCS_APB_ADDR, {20'h0_0000, a}, r);
    apb(1'b1, ncs_pkg::NCS_APB_WDATA, d, r);
    apb(1'b1, ncs_pkg::NCS_APB_CMD, {29'h0, cmd}, r);
    do
      apb(1'b0, ncs_pkg::NCS_APB_STATUS, 32'h0, r);
    while (r[0] !== 1'b0);
    apb(1'b0, ncs_pkg::NCS_APB_RDATA, 32'h0, r);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    dev(3'h1, a, d, r);
  endtask
  task automatic rchk(input string nm, input logic [11:0] a,
                      input logic [31:0] exp);
    logic [31:0] r;
    dev(3'h2, a, 32'h0, r);
    chk(nm, r, exp);
  endtask
  task automatic sref(input int exp);
    int c;
    c = aligns;
    @(posedge mclk);
    ifc.sysref <= 1'b1;
    idle(3);
    ifc.sysref <= 1'b0;
    idle(12);
    chk("sysref_aligns", 32'(aligns - c), 32'(exp));
  endtask
  task automatic lnk(input int exp, input logic rise);
    int c;
    if (rise)
    begin
      @(posedge mclk);
      ifc.sync_n <= 1'b0;
      idle(4);
      ifc.sync_n <= 1'b1;
      idle(8);
    end
    c = aligns;
    @(posedge mclk);
    ifc.boundary <= 1'b1;
    @(posedge mclk);
    ifc.boundary <= 1'b0;
    idle(12);
    chk("link_aligns", 32'(aligns - c), 32'(exp));
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_reset();
    logic [11:0] o;
    for (int k = 0; k < ncs_pkg::NCS_PRESETS; k++)
    begin
      o = 12'(k) * ncs_pkg::NCS_PRESET_STRIDE;
      rchk("freq_rst", FRQ + o, ncs_pkg::NCS_FREQ_RST);
      rchk("phase_rst", PHS + o, 32'h0);
    end
    rchk("sync_rst", SYNC, 32'h0000_0002);
    rchk("rdiv_rst", ncs_pkg::NCS_OFS_RDIV, 32'h0);
    wr(12'h300, 32'hdead_beef);
    rchk("unmapped", 12'h300, 32'h0);
  endtask
  task automatic t_regs();
    logic [31:0] x0;
    int          c0;
    wr(FRQ, 32'h8123_4567);
    rchk("freq_rd", FRQ, 32'h8123_4567);
    @(posedge mclk);
    x0 = nco_phase;
    c0 = cyc;
    wr(PHS, 32'hffff_8001);
    idle(8);
    chk("phase_step", nco_phase,
        x0 + 32'(cyc - c0) * 32'h8123_4567 + 32'h8001_0000);
    rchk("phase_rd", PHS, 32'h0000_8001);
  endtask
  task automatic t_preset();
    for (int s = 3; s >= 0; s--)
    begin
      wr(ncs_pkg::NCS_OFS_PRESET_SEL, 32'(s));
      idle(4);
      chk("preset", {30'h0, active_preset}, 32'(s));
    end
  endtask
  // Divisor of three: four steps in any twelve cycles
  task automatic t_rdiv();
    logic [31:0] x0;
    wr(ncs_pkg::NCS_OFS_RDIV, 32'h0000_0003);
    @(posedge mclk);
    x0 = nco_phase;
    idle(12);
    chk("rdiv_step", nco_phase, x0 + 32'h0000_0004 * 32'h8123_4567);
    wr(ncs_pkg::NCS_OFS_RDIV, 32'h0000_0000);
  endtask
  task automatic t_link();
    for (int e = 0; e < 2; e++)
    begin
      ifc.enc_64b66b <= e[0];
      lnk(1, 1'b1);
      lnk(0, 1'b0);
    end
  endtask
  // Sysref aligns only when armed, once per arm
  task automatic t_sysref();
    logic [31:0] r;
    dev(3'h4, 12'h000, 32'h0, r);
    rchk("armed", SYNC, 32'h0000_0005);
    sref(1);
    sref(0);
    wr(SYNC, 32'h1);
    sref(0);
    wr(SYNC, 32'h0);
    wr(SYNC, 32'h1);
    sref(1);
    lnk(0, 1'b1);
  endtask

  initial
  begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    ifc.sysref = 1'b0;
    ifc.sync_n = 1'b0;
    ifc.boundary = 1'b0;
    ifc.enc_64b66b = 1'b0;
    idle(10);
    resetn <= 1'b1;
    t_reset();
    t_regs();
    t_preset();
    t_rdiv();
    t_link();
    t_sysref();
    stop_test();
  end
endmodule // nco_phase_sync_control_and_presets_tb

/* File: dv/ncs_chk.sv */
// Checker for the register port and the alignment timing of the pair.
// Assumes one clock; instantiated beside the interface by the bench.
`timescale 1ns/1ps
module ncs_chk
(
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_ack,
  input wire logic        sysref,
  input wire logic        sync_n,
  input wire logic        boundary,
  input wire logic [31:0] nco_phase,
  input wire logic [1:0]  active_preset,
  input wire logic        align_pulse
);
  // ****************************************************
  // Shadow state rebuilt from interface traffic
  // ****************************************************
  logic [31:0] freq_reg;
  logic [15:0] phase_reg;
  logic        div_zero_reg;
  logic [3:0]  quiet_reg;
  logic [3:0]  cause_reg;
  logic [3:0]  age_reg;
  logic        req_reg;
  logic        link_en_reg;
  logic        zero_reg;
  logic        armed_reg;
  logic        pend_reg;
  logic        wr_sync;

  assign wr_sync = reg_wr && reg_addr == ncs_pkg::NCS_OFS_SYNC_CTRL;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      freq_reg     <= ncs_pkg::NCS_FREQ_RST;
      phase_reg    <= ncs_pkg::NCS_PHASE_RST;
      div_zero_reg <= 1'b1;
      quiet_reg    <= 4'h0;
      req_reg      <= 1'b0;
    end
    else
    begin
      req_reg   <= reg_wr || reg_rd;
      quiet_reg <= reg_wr ? 4'h0 : quiet_reg + {3'h0, quiet_reg != 4'hf};
      if (reg_wr && reg_addr == ncs_pkg::NCS_OFS_FREQ_A0)
        freq_reg <= reg_wdata;
      if (reg_wr && reg_addr == ncs_pkg::NCS_OFS_PHASE_A0)
        phase_reg <= reg_wdata[15:0];
      if (reg_wr && reg_addr == ncs_pkg::NCS_OFS_RDIV)
        div_zero_reg <= reg_wdata[15:0] == 16'h0000;
    end
  end

  // Arm needs a zero write followed by a one write
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      link_en_reg <= 1'b1;
      zero_reg    <= 1'b0;
      armed_reg   <= 1'b0;
    end
    else if (wr_sync)
    begin
      link_en_reg <= reg_wdata[ncs_pkg::NCS_BIT_LINK_EN];
      zero_reg    <= !reg_wdata[ncs_pkg::NCS_BIT_ARM];
      armed_reg   <= reg_wdata[ncs_pkg::NCS_BIT_ARM] && zero_reg;
    end
    else if (align_pulse)
      armed_reg <= 1'b0;
  end

  // Age of last cause; keeps step checks clear of alignment
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      cause_reg <= 4'hf;
      age_reg   <= 4'h0;
      pend_reg  <= 1'b0;
    end
    else
    begin
      cause_reg <= ($rose(sysref) || boundary) ? 4'h0
                   : cause_reg + {3'h0, cause_reg != 4'hf};
      age_reg   <= $rose(sync_n) ? 4'h0 : age_reg + {3'h0, age_reg != 4'hf};
      if ($rose(sync_n))
        pend_reg <= 1'b1;
      else if (align_pulse)
        pend_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  property p_ack_follows;
    reg_wr || reg_rd |=> reg_ack;
  endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("register ack missing");
  property p_ack_cause;
    reg_ack |-> req_reg;
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("register ack without request");
  property p_align_width;
    align_pulse |=> !align_pulse;
  endproperty
  a_align_width: assert property (p_align_width)
    else $error("alignment pulse too long");
  property p_align_cause;
    align_pulse |-> cause_reg <= 4'h8;
  endproperty
  a_align_cause: assert property (p_align_cause)
    else $error("alignment without a cause");
  property p_link_align;
    boundary && pend_reg && age_reg >= 4'h4 && link_en_reg && sync_n
      |-> ##[1:8] align_pulse;
  endproperty
  a_link_align: assert property (p_link_align)
    else $error("no alignment at link boundary");
  property p_sysref_align;
    $rose(sysref) && armed_reg |-> ##[2:8] align_pulse;
  endproperty
  a_sysref_align: assert property (p_sysref_align)
    else $error("no alignment on armed sysref");
  property p_rearm;
    align_pulse && !link_en_reg |-> armed_reg;
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("alignment while not armed");
  property p_acc_step;
    quiet_reg >= 4'h6 && cause_reg >= 4'hc && active_preset == 2'h0
      && div_zero_reg |-> nco_phase == $past(nco_phase) + freq_reg;
  endproperty
  a_acc_step: assert property (p_acc_step)
    else $error("accumulator step wrong");
  // Phase one cycle after the pulse is the offset alone
  property p_align_clear;
    align_pulse && active_preset == 2'h0
      |=> nco_phase == {phase_reg, 16'h0000};
  endproperty
  a_align_clear: assert property (p_align_clear)
    else $error("alignment did not clear accumulator");
endmodule // ncs_chk

/* File: hw/ncs_ctl.sv */
// Controller: APB slave that issues device register accesses and
// runs the multi-device arm sequence. Assumes ncs_if ctl side.
`timescale 1ns/1ps
module ncs_ctl
(
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic psel,
  input  wire logic penable,
  input  wire logic pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  ncs_if.ctl          bus
);
  ncs_pkg::ncs_ctl_state_t st_reg;
  logic [11:0] addr_reg;
  logic [31:0] wdata_reg;
  logic [31:0] rdata_reg;
  logic        busy_reg;
  logic        acc;

  assign acc = psel && penable && pready;

  // ****************************************************
  // APB slave
  // ****************************************************
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite)
        case (paddr)
          ncs_pkg::NCS_APB_ADDR:   prdata <= {20'h0, addr_reg};
          ncs_pkg::NCS_APB_WDATA:  prdata <= wdata_reg;
          ncs_pkg::NCS_APB_RDATA:  prdata <= rdata_reg;
          ncs_pkg::NCS_APB_STATUS: prdata <= {31'h0, busy_reg};
          default:                 prdata <= 32'h0000_0000;
        endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      addr_reg  <= 12'h000;
      wdata_reg <= 32'h0000_0000;
    end
    else if (acc && pwrite)
    begin
      if (paddr == ncs_pkg::NCS_APB_ADDR)
        addr_reg <= pwdata[11:0];
      if (paddr == ncs_pkg::NCS_APB_WDATA)
        wdata_reg <= pwdata;
    end
  end

  // ****************************************************
  // Device access engine
  // ****************************************************
  // Software must keep sysref quiet and the link up before align
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      st_reg        <= ncs_pkg::NCS_IDLE;
      busy_reg      <= 1'b0;
      rdata_reg     <= 32'h0000_0000;
      bus.reg_wr    <= 1'b0;
      bus.reg_rd    <= 1'b0;
      bus.reg_addr  <= 12'h000;
      bus.reg_wdata <= 32'h0000_0000;
    end
    else
    begin
      bus.reg_wr <= 1'b0;
      bus.reg_rd <= 1'b0;
      if (bus.reg_ack && busy_reg && st_reg == ncs_pkg::NCS_IDLE)
      begin
        rdata_reg <= bus.reg_rdata;
        busy_reg  <= 1'b0;
      end
      case (st_reg)
        ncs_pkg::NCS_IDLE:
          if (acc && pwrite && paddr == ncs_pkg::NCS_APB_CMD && !busy_reg)
          begin
            busy_reg <= 1'b1;
            if (pwdata[ncs_pkg::NCS_CMD_ALIGN])
              st_reg <= ncs_pkg::NCS_CLR;
            else
            begin
              bus.reg_addr  <= addr_reg;
              bus.reg_wdata <= wdata_reg;
              bus.reg_wr    <= pwdata[ncs_pkg::NCS_CMD_WRITE];
              bus.reg_rd    <= pwdata[ncs_pkg::NCS_CMD_READ];
            end
          end
        ncs_pkg::NCS_CLR:
        begin
          bus.reg_addr  <= ncs_pkg::NCS_OFS_SYNC_CTRL;
          bus.reg_wdata <= 32'h0000_0000;
          bus.reg_wr    <= 1'b1;
          st_reg        <= ncs_pkg::NCS_ARM0;
        end
        ncs_pkg::NCS_ARM0:
          st_reg <= ncs_pkg::NCS_ARM1;
        ncs_pkg::NCS_ARM1:
        begin
          bus.reg_wdata <= 32'h0000_0001;
          bus.reg_wr    <= 1'b1;
          st_reg        <= ncs_pkg::NCS_DONE;
        end
        ncs_pkg::NCS_DONE:
        begin
          busy_reg <= 1'b0;
          st_reg   <= ncs_pkg::NCS_IDLE;
        end
        default:
          st_reg <= ncs_pkg::NCS_IDLE;
      endcase
    end
  end
endmodule // ncs_ctl

/* File: hw/ncs_device.sv */
// NCO preset registers, phase accumulator and phase alignment.
// Assumes the register port of ncs_if; sysref, sync_n and the
// boundary strobe come from other timing logic and are resampled.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module ncs_device
(
  input  wire logic mclk,
  input  wire logic resetn,
  ncs_if.dev        bus,
  output logic [31:0] nco_phase,
  output logic [1:0]  active_preset,
  output logic        align_pulse
);
  // ****************************************************
  // Registers
  // ****************************************************
  logic [31:0] freq_reg [ncs_pkg::NCS_PRESETS];
  logic [15:0] phase_reg [ncs_pkg::NCS_PRESETS];
  logic [1:0]  preset_select_chan_a_reg;
  logic [15:0] nco_reference_divisor_reg;
  logic        link_start_phase_align_en_reg;
  logic        sysref_phase_align_arm_reg;
  logic        arm_zero_seen_reg;
  logic        armed_reg;
  logic [31:0] acc_reg;
  logic [15:0] rdiv_cnt_reg;
  logic        sysref_q;
  logic        sysref_d_reg;
  logic        sync_q;
  logic        sync_d_reg;
  logic        sync_pending_reg;
  logic        boundary_q;
  logic        enc_q;
  logic        wr_sync;
  logic        sysref_rise;
  logic        link_align;
  logic        sysref_align;
  logic        do_align;
  logic        step_en;
  logic [2:0]  freq_hit;
  logic [2:0]  phase_hit;

  ncs_sync2 u_sysref
  (
    .mclk    (mclk),
    .resetn  (resetn),
    .din     (bus.sysref),
    .rst_val (1'b0),
    .dout    (sysref_q)
  );
  ncs_sync2 u_sync
  (
    .mclk    (mclk),
    .resetn  (resetn),
    .din     (bus.sync_n),
    .rst_val (1'b0),
    .dout    (sync_q)
  );
  ncs_sync2 u_bnd
  (
    .mclk    (mclk),
    .resetn  (resetn),
    .din     (bus.boundary),
    .rst_val (1'b0),
    .dout    (boundary_q)
  );
  ncs_sync2 u_enc
  (
    .mclk    (mclk),
    .resetn  (resetn),
    .din     (bus.enc_64b66b),
    .rst_val (1'b0),
    .dout    (enc_q)
  );

  function automatic logic [2:0] preset_hit(input logic [11:0] a,
                                            input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    preset_hit = {(d[11:5] == 7'd0) && (d[2:0] == 3'd0), d[4:3]};
  endfunction

  assign wr_sync = bus.reg_wr && (bus.reg_addr == ncs_pkg::NCS_OFS_SYNC_CTRL);

  // ****************************************************
  // Register writes
  // ****************************************************
  assign freq_hit  = preset_hit(bus.reg_addr, ncs_pkg::NCS_OFS_FREQ_A0);
  assign phase_hit = preset_hit(bus.reg_addr, ncs_pkg::NCS_OFS_PHASE_A0);
  genvar g;
  generate
    for (g = 0; g < ncs_pkg::NCS_PRESETS; g++)
    begin : g_preset
      always_ff @(posedge mclk)
      begin
        if (!resetn)
        begin
          freq_reg[g]  <= ncs_pkg::NCS_FREQ_RST;
          phase_reg[g] <= ncs_pkg::NCS_PHASE_RST;
        end
        else
        begin
          if (bus.reg_wr && freq_hit[2] && freq_hit[1:0] == 2'(g))
            freq_reg[g] <= bus.reg_wdata;
          if (bus.reg_wr && phase_hit[2] && phase_hit[1:0] == 2'(g))
            phase_reg[g] <= bus.reg_wdata[15:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      preset_select_chan_a_reg      <= 2'h0;
      nco_reference_divisor_reg     <= 16'h0000;
      link_start_phase_align_en_reg <= ncs_pkg::NCS_SYNC_RST[1];
      sysref_phase_align_arm_reg    <= ncs_pkg::NCS_SYNC_RST[0];
    end
    else
    begin
      if (bus.reg_wr && bus.reg_addr == ncs_pkg::NCS_OFS_PRESET_SEL)
        preset_select_chan_a_reg <= bus.reg_wdata[1:0];
      if (bus.reg_wr && bus.reg_addr == ncs_pkg::NCS_OFS_RDIV)
        nco_reference_divisor_reg <= bus.reg_wdata[15:0];
      if (wr_sync)
      begin
        link_start_phase_align_en_reg <=
          bus.reg_wdata[ncs_pkg::NCS_BIT_LINK_EN];
        sysref_phase_align_arm_reg <= bus.reg_wdata[ncs_pkg::NCS_BIT_ARM];
      end
    end
  end

  // ****************************************************
  // Arm sequence: a zero write, then a one write
  // ****************************************************
  assign sysref_rise  = sysref_q && !sysref_d_reg;
  assign sysref_align = armed_reg && sysref_rise;
  // Boundary after sync rise; same path for both encodings, sync
  // touches nothing else here so 64B/66B link stays unaffected
  assign link_align   = link_start_phase_align_en_reg && sync_pending_reg
                        && boundary_q;
  assign do_align     = sysref_align || link_align;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      arm_zero_seen_reg <= 1'b0;
      armed_reg         <= 1'b0;
      sysref_d_reg      <= 1'b0;
      sync_d_reg        <= 1'b0;
      sync_pending_reg  <= 1'b0;
    end
    else
    begin
      sysref_d_reg <= sysref_q;
      sync_d_reg   <= sync_q;
      if (wr_sync && !bus.reg_wdata[ncs_pkg::NCS_BIT_ARM])
      begin
        arm_zero_seen_reg <= 1'b1;
        armed_reg         <= 1'b0;
      end
      else if (wr_sync && arm_zero_seen_reg)
      begin
        arm_zero_seen_reg <= 1'b0;
        armed_reg         <= 1'b1;
      end
      else if (sysref_align)
        armed_reg <= 1'b0;
      if (sync_q && !sync_d_reg)
        sync_pending_reg <= 1'b1;
      else if (link_align || !sync_q)
        sync_pending_reg <= 1'b0;
    end
  end

  // ****************************************************
  // Phase accumulator
  // ****************************************************
  // Divisor modelled as a sample gate; zero means every sample
  assign step_en = (nco_reference_divisor_reg == 16'h0000) ||
                   (rdiv_cnt_reg == 16'h0000);

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      acc_reg      <= 32'h0000_0000;
      rdiv_cnt_reg <= 16'h0000;
    end
    else if (do_align)
    begin
      acc_reg      <= 32'h0000_0000;
      rdiv_cnt_reg <= 16'h0000;
    end
    else
    begin
      // Parked at zero while off, so a new divisor starts at once
      if (nco_reference_divisor_reg == 16'h0000)
        rdiv_cnt_reg <= 16'h0000;
      else
        rdiv_cnt_reg <= step_en ? 16'(nco_reference_divisor_reg - 16'h0001)
                                : 16'(rdiv_cnt_reg - 16'h0001);
      if (step_en)
        acc_reg <= acc_reg + freq_reg[preset_select_chan_a_reg];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      nco_phase     <= 32'h0000_0000;
      active_preset <= 2'h0;
      align_pulse   <= 1'b0;
    end
    else
    begin
      nco_phase     <= acc_reg +
                       {phase_reg[preset_select_chan_a_reg], 16'h0000};
      active_preset <= preset_select_chan_a_reg;
      align_pulse   <= do_align;
    end
  end

  // ****************************************************
  // Register reads, one cycle
  // ****************************************************
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      bus.reg_rdata <= 32'h0000_0000;
      bus.reg_ack   <= 1'b0;
    end
    else
    begin
      bus.reg_ack <= bus.reg_wr || bus.reg_rd;
      if (bus.reg_rd)
      begin
        if (freq_hit[2])
          bus.reg_rdata <= freq_reg[freq_hit[1:0]];
        else if (phase_hit[2])
          bus.reg_rdata <= {16'h0000, phase_reg[phase_hit[1:0]]};
        else if (bus.reg_addr == ncs_pkg::NCS_OFS_SYNC_CTRL)
          bus.reg_rdata <= {29'h0, armed_reg,
                            link_start_phase_align_en_reg,
                            sysref_phase_align_arm_reg};
        else if (bus.reg_addr == ncs_pkg::NCS_OFS_RDIV)
          bus.reg_rdata <= {16'h0000, nco_reference_divisor_reg};
        else if (bus.reg_addr == ncs_pkg::NCS_OFS_PRESET_SEL)
          bus.reg_rdata <= {30'h0, preset_select_chan_a_reg};
        else
          bus.reg_rdata <= 32'h0000_0000;
      end
    end
  end

  logic unused_enc;
  assign unused_enc = enc_q;
endmodule // ncs_device

/* File: hw/ncs_sync2.sv */
// Two-flop synchroniser for pins from outside the clock domain.
// Assumes the input is a slow level compared with mclk.
`timescale 1ns/1ps
module ncs_sync2
(
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic din,
  input  wire logic rst_val,
  output logic      dout
);
  logic meta_reg;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      meta_reg <= rst_val;
      dout     <= rst_val;
    end
    else
    begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule // ncs_sync2

/* File: include/ncs_if.sv */
// Register port and timing signals between controller and device.
// Assumes one clock; the device samples sysref and sync through
// its own synchronisers.
`timescale 1ns/1ps
interface ncs_if;
  logic        reg_wr;
  logic        reg_rd;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        reg_ack;
  logic        sysref;
  logic        sync_n;
  logic        boundary;
  logic        enc_64b66b;

  modport dev
  (
    input  reg_wr, reg_rd, reg_addr, reg_wdata, sysref, sync_n,
           boundary, enc_64b66b,
    output reg_rdata, reg_ack
  );
  modport ctl
  (
    output reg_wr, reg_rd, reg_addr, reg_wdata,
    input  reg_rdata, reg_ack
  );
endinterface

/* File: include/ncs_pkg.sv */
// Constants, register map and types shared by the Nco_phase_sync_control device
// and its controller. Assumes a single 125 MHz clock domain.
// How it works
// - Link-start enable aligns phase at boundary after sync
// - Link-start alignment works in both encodings
// - In 64B/66B sync only triggers phase alignment
// - Arm write zero then one; next sysref aligns
// - After sysref alignment, ignore edges until rearmed
// - Controller arms only with sysref quiet, link up; the controller does not check either, software must
// - Controller clears link-start enable, writes zero, one
// - Sysref pulses; armed device aligns on first edge
// - Frequency word 32 bits, any sign reading
// - Software rounds word when divisor used
// - Every preset frequency word resets to C0000000
// - Resynchronise after changing a running word
// - Phase left justified and added to accumulator
// - Phase offset resets zero, any sign reading
// - Two-bit select picks one of four presets
// - Divisor zero gives plain 32-bit accumulator
package ncs_pkg;

  // ****************************************************
  // Device register offsets
  // ****************************************************
  localparam logic [11:0] NCS_OFS_SYNC_CTRL  = 12'h0219;
  localparam logic [11:0] NCS_OFS_RDIV       = 12'h0217;
  localparam logic [11:0] NCS_OFS_PRESET_SEL = 12'h0210;
  localparam logic [11:0] NCS_OFS_FREQ_A0    = 12'h0220;
  localparam logic [11:0] NCS_OFS_PHASE_A0   = 12'h0224;
  localparam logic [11:0] NCS_PRESET_STRIDE  = 12'h0008;

  // ****************************************************
  // Reset values and field positions
  // ****************************************************
  localparam logic [31:0] NCS_FREQ_RST       = 32'hc000_0000;
  localparam logic [15:0] NCS_PHASE_RST      = 16'h0000;
  localparam logic [7:0]  NCS_SYNC_RST       = 8'h02;
  localparam int          NCS_BIT_ARM        = 0;
  localparam int          NCS_BIT_LINK_EN    = 1;
  localparam int          NCS_PRESETS        = 4;

  // ****************************************************
  // Controller APB register offsets
  // ****************************************************
  localparam logic [7:0]  NCS_APB_CMD        = 8'h00;
  localparam logic [7:0]  NCS_APB_ADDR       = 8'h04;
  localparam logic [7:0]  NCS_APB_WDATA      = 8'h08;
  localparam logic [7:0]  NCS_APB_RDATA      = 8'h0c;
  localparam logic [7:0]  NCS_APB_STATUS     = 8'h10;
  localparam int          NCS_CMD_WRITE      = 0;
  localparam int          NCS_CMD_READ       = 1;
  localparam int          NCS_CMD_ALIGN      = 2;

  typedef enum logic [2:0]
  {
    NCS_IDLE  = 3'b000,
    NCS_CLR   = 3'b001,
    NCS_ARM0  = 3'b011,
    NCS_ARM1  = 3'b010,
    NCS_DONE  = 3'b110
  } ncs_ctl_state_t;

endpackage
